// [brc_host.sv]
`timescale 1ns/1ps
module brc_host (
	input wire logic core_clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda,
	output logic obs_tog,
	output logic [7:0] obs_data
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		obs_tog = 1'b0;
		obs_data = 8'h00;
	end
	task automatic clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// SDA moves only mid low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		clk(2);
		sda <= b;
		clk(2);
		scl <= 1'b1;
		clk(2);
		r = sda_in;
		clk(2);
	endtask
	// Start is cond(1, 0), stop is cond(0, 1)
	task automatic cond(input logic first, input logic last);
		scl <= 1'b0;
		clk(2);
		sda <= first;
		clk(2);
		scl <= 1'b1;
		clk(4);
		sda <= last;
		clk(4);
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, input logic rd);
		logic [7:0] q;
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(m, a);
		obs_data <= rd ? q : {7'h00, a};
		obs_tog <= ~obs_tog;
	endtask
endmodule // brc_host

// [brc_pkg.sv]
package brc_pkg;

	// Register map
	localparam logic [7:0] RAIL4_CONTROL_OFFSET = 8'h25;
	localparam logic [7:0] RAIL5_CONTROL_OFFSET = 8'h26;
	localparam logic [7:0] RAIL6_CONTROL_OFFSET = 8'h27;
	localparam int RAIL_COUNT = 3;
	localparam logic [RAIL_COUNT-1:0][7:0] RAIL_OFFSETS = {
		RAIL6_CONTROL_OFFSET, RAIL5_CONTROL_OFFSET, RAIL4_CONTROL_OFFSET};

	// Field layout of a rail control register
	localparam int SLEEP_SEL_MSB = 5;
	localparam int SLEEP_SEL_LSB = 4;
	localparam int RSVD_MSB = 3;
	localparam int RSVD_LSB = 2;
	localparam int OP_MODE_BIT = 1;
	localparam int SW_ENABLE_BIT = 0;
	localparam logic [1:0] SLEEP_SEL_OFF = 2'h0;
	localparam logic [1:0] SLEEP_SEL_ON = 2'h3;
	localparam logic [1:0] UPPER_BITS_READ = 2'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Factory reset contents (bits 3:2 always 11)
	localparam logic [7:0] RAIL4_RESET = 8'h0f;
	localparam logic [7:0] RAIL5_RESET = 8'h0f;
	localparam logic [7:0] RAIL6_RESET = 8'h0f;
	localparam logic [RAIL_COUNT-1:0][7:0] RAIL_RESETS = {RAIL6_RESET, RAIL5_RESET, RAIL4_RESET};

	// Factory sleep pin assignment: 0 = control_in3_sleep_a, 1 = control_in6_sleep_b
	localparam logic [RAIL_COUNT-1:0] RAIL_SLEEP_PIN_B = 3'h0;

	// Serial target address, arbitrary value
	localparam logic [6:0] I2C_DEV_ADDR = 7'h5e;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_RX = 6'h08,
		ST_TX = 6'h10,
		ST_MACK = 6'h20
	} brc_state_type;

endpackage

// [brc_rail_ctrl.sv]
`timescale 1ns/1ps
// Functional notes
// - Sleep select 00 keeps normal code; 11 uses sleep code while sleep pin low.
// - Each rail's sleep pin is factory fixed: control input three or six.
// - Bit 1 picks operating mode: 0 automatic, 1 forced PWM.
// - Bit 0 cleared forces rail off regardless of control pins; 1 allows it.
// - Fifth rail control at 26h, sixth at 27h, factory reset contents.
// - Fourth rail control at 25h, factory reset contents.
module brc_rail_ctrl
	import brc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic control_in3_sleep_a,
	input wire logic control_in6_sleep_b,
	input wire logic [RAIL_COUNT-1:0] rail_pin_request,
	output logic [RAIL_COUNT-1:0] rail_use_sleep_code,
	output logic [RAIL_COUNT-1:0] rail_forced_pwm,
	output logic [RAIL_COUNT-1:0] rail_enable
);
	brc_state_type state_r;
	brc_state_type state_nxt;
	logic scl_q_r;
	logic sda_q_r;
	logic [2:0] bit_cnt_r;
	logic [2:0] bit_cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic byte_done_r;
	logic byte_done_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic first_r;
	logic first_nxt;
	logic read_r;
	logic read_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic mack_r;
	logic mack_nxt;
	logic wr_stb_r;
	logic wr_stb_nxt;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_addr_nxt;
	logic [7:0] wr_data_r;
	logic [7:0] wr_data_nxt;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic [7:0] rd_mux;
	logic [RAIL_COUNT-1:0][7:0] rd_each;

	brc_rail_if rif[RAIL_COUNT] ();

	// Bus line events
	assign start_seen = scl_in && scl_q_r && sda_q_r && !sda_in;
	assign stop_seen = scl_in && scl_q_r && !sda_q_r && sda_in;
	assign scl_rise = scl_in && !scl_q_r;
	assign scl_fall = !scl_in && scl_q_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	genvar g;
	generate
		for (g = 0; g < RAIL_COUNT; g++) begin : g_rail
			assign rif[g].wr_stb = wr_stb_r && (wr_addr_r == RAIL_OFFSETS[g]);
			assign rif[g].wr_data = wr_data_r;
			assign rif[g].sleep_pin_a = control_in3_sleep_a;
			assign rif[g].sleep_pin_b = control_in6_sleep_b;
			assign rif[g].pin_request = rail_pin_request[g];
			assign rd_each[g] = rif[g].rd_data;
			assign rail_use_sleep_code[g] = rif[g].use_sleep_code;
			assign rail_forced_pwm[g] = rif[g].forced_pwm;
			assign rail_enable[g] = rif[g].rail_on;

			brc_rail_reg #(
				.RESET_VALUE(RAIL_RESETS[g]),
				.SLEEP_PIN_B(RAIL_SLEEP_PIN_B[g])
			) u_rail (
				.core_clk(core_clk),
				.rst(rst),
				.port(rif[g])
			);
		end
	endgenerate

	// Read data for the current pointer; unmapped offsets read zero
	always_comb begin
		rd_mux = UNMAPPED_READ;
		for (int i = 0; i < RAIL_COUNT; i++) begin
			if (ptr_r == RAIL_OFFSETS[i]) begin
				rd_mux = rd_each[i];
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		byte_done_nxt = byte_done_r;
		ptr_nxt = ptr_r;
		first_nxt = first_r;
		read_nxt = read_r;
		tx_nxt = tx_r;
		oe_n_nxt = oe_n_r;
		mack_nxt = mack_r;
		wr_stb_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		if (start_seen) begin
			state_nxt = ST_ADDR;
			bit_cnt_nxt = 3'h0;
			byte_done_nxt = 1'b0;
			oe_n_nxt = 1'b1;
		end else if (stop_seen) begin
			state_nxt = ST_IDLE;
			oe_n_nxt = 1'b1;
		end else begin
			case (state_r)
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_in};
						bit_cnt_nxt = bit_cnt_r + 3'h1;
						if (bit_cnt_r == LAST_BIT) begin
							byte_done_nxt = 1'b1;
						end
					end else if (scl_fall && byte_done_r) begin
						byte_done_nxt = 1'b0;
						if (state_r == ST_ADDR) begin
							if (shift_r[7:1] == I2C_DEV_ADDR) begin
								state_nxt = ST_ACK;
								oe_n_nxt = 1'b0;
								read_nxt = shift_r[0];
								first_nxt = !shift_r[0];
							end else begin
								state_nxt = ST_IDLE;
							end
						end else begin
							state_nxt = ST_ACK;
							oe_n_nxt = 1'b0;
							if (first_r) begin
								ptr_nxt = shift_r;
								first_nxt = 1'b0;
							end else begin
								wr_stb_nxt = 1'b1;
								wr_addr_nxt = ptr_r;
								wr_data_nxt = shift_r;
								ptr_nxt = ptr_r + 8'h01;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = 3'h0;
						if (read_r) begin
							state_nxt = ST_TX;
							tx_nxt = rd_mux;
							oe_n_nxt = rd_mux[7];
							ptr_nxt = ptr_r + 8'h01;
						end else begin
							state_nxt = ST_RX;
							oe_n_nxt = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_r == LAST_BIT) begin
							state_nxt = ST_MACK;
							oe_n_nxt = 1'b1;
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							oe_n_nxt = tx_r[6];
							bit_cnt_nxt = bit_cnt_r + 3'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_nxt = !sda_in;
					end else if (scl_fall) begin
						if (mack_r) begin
							state_nxt = ST_TX;
							bit_cnt_nxt = 3'h0;
							tx_nxt = rd_mux;
							oe_n_nxt = rd_mux[7];
							ptr_nxt = ptr_r + 8'h01;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				default: begin
					state_nxt = ST_IDLE;
					oe_n_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
			byte_done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			byte_done_r <= byte_done_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ptr_r <= 8'h00;
			first_r <= 1'b0;
			read_r <= 1'b0;
		end else begin
			ptr_r <= ptr_nxt;
			first_r <= first_nxt;
			read_r <= read_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_r <= 8'h00;
			oe_n_r <= 1'b1;
			mack_r <= 1'b0;
		end else begin
			tx_r <= tx_nxt;
			oe_n_r <= oe_n_nxt;
			mack_r <= mack_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_stb_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else begin
			wr_stb_r <= wr_stb_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_r;
endmodule // brc_rail_ctrl

// [brc_rail_ctrl_monitor.sv]
`timescale 1ns/1ps
module brc_rail_ctrl_monitor
	import brc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_oe_n,
	input wire logic control_in3_sleep_a,
	input wire logic [2:0] rail_pin_request,
	input wire logic [2:0] rail_use_sleep_code,
	input wire logic [2:0] rail_forced_pwm,
	input wire logic [2:0] rail_enable
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_EN_PIN: assert property ((rail_enable & ~$past(rail_pin_request)) == 3'h0)
		else $error("rail on without request");
	AST_EN_DROP: assert property ($fell(rail_pin_request[1]) |=> !rail_enable[1])
		else $error("rail stayed on");
	AST_SLP_PIN: assert property (rail_use_sleep_code != 3'h0 |-> !$past(control_in3_sleep_a))
		else $error("sleep code with pin high");
	AST_SLP_DROP: assert property ($rose(control_in3_sleep_a) |=> rail_use_sleep_code == 3'h0)
		else $error("sleep code held");
	AST_RST_PWM: assert property ($fell(rst) |=> rail_forced_pwm == 3'h7)
		else $error("mode wrong after reset");
	AST_RST_EN: assert property ($fell(rst) |=> rail_enable == $past(rail_pin_request))
		else $error("enable wrong after reset");
	AST_RST_SLP: assert property ($fell(rst) |=> rail_use_sleep_code == 3'h0)
		else $error("sleep wrong after reset");
	AST_SDA_STILL: assert property (scl_in [*4] |-> $stable(sda_oe_n))
		else $error("data moved while clock high");
endmodule // brc_rail_ctrl_monitor

bind brc_rail_ctrl brc_rail_ctrl_monitor u_brc_rail_ctrl_monitor (.core_clk, .rst, .scl_in,
	.sda_oe_n, .control_in3_sleep_a, .rail_pin_request, .rail_use_sleep_code, .rail_forced_pwm,
	.rail_enable);

// [brc_rail_if.sv]
`timescale 1ns/1ps
interface brc_rail_if;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic sleep_pin_a;
	logic sleep_pin_b;
	logic pin_request;
	logic use_sleep_code;
	logic forced_pwm;
	logic rail_on;

	modport bank (
		output wr_stb, wr_data, sleep_pin_a, sleep_pin_b, pin_request,
		input rd_data, use_sleep_code, forced_pwm, rail_on
	);
	modport rail (
		input wr_stb, wr_data, sleep_pin_a, sleep_pin_b, pin_request,
		output rd_data, use_sleep_code, forced_pwm, rail_on
	);
endinterface

// [brc_rail_reg.sv]
`timescale 1ns/1ps
module brc_rail_reg
	import brc_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = RAIL4_RESET,
	parameter logic SLEEP_PIN_B = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	brc_rail_if.rail port
);
	logic [1:0] sleep_sel_r;
	logic [1:0] rsvd_r;
	logic op_mode_r;
	logic sw_enable_r;
	logic use_sleep_r;
	logic forced_pwm_r;
	logic rail_on_r;
	logic sleep_pin;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_sel_r <= RESET_VALUE[SLEEP_SEL_MSB:SLEEP_SEL_LSB];
			rsvd_r <= RESET_VALUE[RSVD_MSB:RSVD_LSB];
			op_mode_r <= RESET_VALUE[OP_MODE_BIT];
			sw_enable_r <= RESET_VALUE[SW_ENABLE_BIT];
		end else if (port.wr_stb) begin
			// Bits 7:6 are dropped on write
			sleep_sel_r <= port.wr_data[SLEEP_SEL_MSB:SLEEP_SEL_LSB];
			rsvd_r <= port.wr_data[RSVD_MSB:RSVD_LSB];
			op_mode_r <= port.wr_data[OP_MODE_BIT];
			sw_enable_r <= port.wr_data[SW_ENABLE_BIT];
		end
	end

	assign port.rd_data = {UPPER_BITS_READ, sleep_sel_r, rsvd_r, op_mode_r, sw_enable_r};

	// Factory-fixed choice of governing sleep pin
	assign sleep_pin = SLEEP_PIN_B ? port.sleep_pin_b : port.sleep_pin_a;

	// Only 11 selects the sleep code; reserved 01 and 10 behave as 00
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			use_sleep_r <= 1'b0;
		end else begin
			use_sleep_r <= (sleep_sel_r == SLEEP_SEL_ON) && !sleep_pin;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			forced_pwm_r <= 1'b0;
		end else begin
			forced_pwm_r <= op_mode_r;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rail_on_r <= 1'b0;
		end else begin
			rail_on_r <= sw_enable_r && port.pin_request;
		end
	end

	assign port.use_sleep_code = use_sleep_r;
	assign port.forced_pwm = forced_pwm_r;
	assign port.rail_on = rail_on_r;
endmodule // brc_rail_reg

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	import brc_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic control_in3_sleep_a = 1'b1;
	logic control_in6_sleep_b = 1'b1;
	logic [2:0] rail_pin_request = 3'h7;
	logic [2:0] rail_use_sleep_code, rail_forced_pwm, rail_enable;
	logic scl, sda, sda_out, sda_oe_n, obs_tog;
	logic obs_prev = 1'b0;
	logic snap_tog = 1'b0;
	logic snap_prev = 1'b0;
	logic [7:0] obs_data;
	logic [7:0] regs [3];
	logic [8:0] exp_q [$];
	int miscompares = 0;
	int tests_run = 0;
	int seed = 65;
	wire logic sda_in = sda & (sda_oe_n | sda_out);
	always #12.5 core_clk = ~core_clk;
	brc_rail_ctrl u_brc_rail_ctrl (.core_clk, .rst, .scl_in(scl), .sda_in, .sda_out, .sda_oe_n,
		.control_in3_sleep_a, .control_in6_sleep_b, .rail_pin_request, .rail_use_sleep_code,
		.rail_forced_pwm, .rail_enable);
	brc_host u_brc_host (.core_clk, .sda_in, .scl, .sda, .obs_tog, .obs_data);
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge core_clk) begin
		obs_prev <= obs_tog;
		snap_prev <= snap_tog;
		if (obs_tog !== obs_prev) check({1'b0, obs_data}, exp_q.pop_front());
		if (snap_tog !== snap_prev) begin
			check({rail_use_sleep_code, rail_forced_pwm, rail_enable}, exp_q.pop_front());
		end
	end
	function automatic logic [8:0] reg_exp(input logic [7:0] a);
		if (a >= RAIL4_CONTROL_OFFSET && a <= RAIL6_CONTROL_OFFSET) begin
			return {1'b0, regs[a - RAIL4_CONTROL_OFFSET]};
		end
		return 9'h000;
	endfunction
	task automatic snap();
		logic [8:0] e;
		for (int i = 0; i < 3; i++) begin
			e[6 + i] = regs[i][5:4] == 2'b11 && !control_in3_sleep_a;
			e[3 + i] = regs[i][1];
			e[i] = regs[i][0] & rail_pin_request[i];
		end
		exp_q.push_back(e);
		snap_tog <= ~snap_tog;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		repeat (3) exp_q.push_back(9'h000);
		u_brc_host.cond(1'b1, 1'b0);
		u_brc_host.xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, 1'b0);
		u_brc_host.xfer(p, 1'b1, 1'b0);
		u_brc_host.xfer(d, 1'b1, 1'b0);
		u_brc_host.cond(1'b0, 1'b1);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		repeat (3) exp_q.push_back(9'h000);
		for (int i = 0; i < n; i++) exp_q.push_back(reg_exp(p + 8'(i)));
		u_brc_host.cond(1'b1, 1'b0);
		u_brc_host.xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, 1'b0);
		u_brc_host.xfer(p, 1'b1, 1'b0);
		u_brc_host.cond(1'b1, 1'b0);
		u_brc_host.xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, 1'b0);
		for (int i = 1; i <= n; i++) u_brc_host.xfer(8'hff, 1'(i == n), 1'b1);
		u_brc_host.cond(1'b0, 1'b1);
	endtask
	task automatic reset_run(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < 3; i++) regs[i] = RAIL_RESETS[i];
		rd(RAIL4_CONTROL_OFFSET, 3);
		snap();
		$display("reset test done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		final_report();
	end
	initial begin
		logic [7:0] d;
		reset_run(10);
		for (int n = 0; n < 12; n++) begin
			d = 8'($random(seed));
			d[3:2] = 2'b11;
			d[5:4] = {2{d[5]}};
			regs[n % 3] = {2'b00, d[5:0]};
			rail_pin_request <= 3'($random(seed));
			control_in3_sleep_a <= 1'($random(seed));
			// Pin B is not assigned to any rail, so it must have no effect
			control_in6_sleep_b <= 1'($random(seed));
			wr(RAIL4_CONTROL_OFFSET + 8'(n % 3), d);
			rd(RAIL4_CONTROL_OFFSET + 8'(n % 3), 1);
			snap();
		end
		$display("random write test done");
		wr(RAIL5_CONTROL_OFFSET, 8'hfc);
		regs[1] = 8'h3c;
		// Read without a new pointer continues after the last written register
		exp_q.push_back(9'h000);
		exp_q.push_back(reg_exp(RAIL6_CONTROL_OFFSET));
		u_brc_host.cond(1'b1, 1'b0);
		u_brc_host.xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, 1'b0);
		u_brc_host.xfer(8'hff, 1'b1, 1'b1);
		u_brc_host.cond(1'b0, 1'b1);
		for (int p = 0; p < 2; p++) begin
			control_in3_sleep_a <= p[0];
			repeat (2) @(posedge core_clk);
			snap();
		end
		rd(RAIL5_CONTROL_OFFSET, 3);
		$display("sleep and burst test done");
		exp_q.push_back(9'h001);
		u_brc_host.cond(1'b1, 1'b0);
		u_brc_host.xfer({I2C_DEV_ADDR + 7'h01, 1'b0}, 1'b1, 1'b0);
		u_brc_host.cond(1'b0, 1'b1);
		$display("address test done");
		reset_run(3);
		final_report();
	end
endmodule // testbench
